//--- design/pmbev_pkg.sv
// Shared constants and carrier types for the power-module command block.
// Assumes a 25 MHz core clock and a word-aligned AXI4-Lite register map.
package pmbev_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int EVT_PREP_NS   = 30000;
   localparam int EVT_PREP_CYC  = EVT_PREP_NS / CLK_PERIOD_NS;
   localparam int EVT_SLOTS     = 48;
   localparam int EVT_BYTES     = 23;
   localparam int EVT_BITS      = EVT_BYTES * 8;

   localparam logic [7:0] CMD_ON_OFF_CFG  = 8'h02;
   localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
   localparam logic [7:0] CMD_STORE_USER  = 8'h15;
   localparam logic [7:0] CMD_VOUT_SET    = 8'h21;
   localparam logic [7:0] CMD_VOUT_TRIM   = 8'h22;
   localparam logic [7:0] CMD_VIN_ON      = 8'h35;
   localparam logic [7:0] CMD_VIN_OFF     = 8'h36;
   localparam logic [7:0] CMD_READ_EVENT  = 8'hD7;
   localparam logic [7:0] CMD_EVENT_INDEX = 8'hDB;
   localparam logic [7:0] CMD_AUX_SETUP   = 8'hF9;

   localparam logic [7:0] BLOCK_COUNT = 8'h17;
   localparam logic [7:0] EMPTY_BYTE  = 8'hFF;
   localparam logic [7:0] IDX_LAST    = 8'h2F;
   localparam logic [7:0] CRC_POLY    = 8'h07;

   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_EVDATA = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_CFG    = 8'h0C;
   localparam logic [7:0] REG_VOUT   = 8'h10;
   localparam logic [7:0] REG_VIN    = 8'h14;

   localparam int ONOFF_SEC_POS_BIT = 0;
   localparam int AUX_ENABLE_BIT    = 0;
   localparam int AUX_PULLUP_BIT    = 1;

   typedef struct packed {
      logic [15:0] vout_set;
      logic [15:0] vout_trim;
      logic [15:0] vin_on;
      logic [15:0] vin_off;
      logic [7:0]  onoff_cfg;
      logic [7:0]  aux_setup;
   } pmbev_cfg_t;

   localparam pmbev_cfg_t FACTORY_CFG = '{
      vout_set: 16'h1833, vout_trim: 16'h0000,
      vin_on: 16'h0060, vin_off: 16'h0058,
      onoff_cfg: 8'h00, aux_setup: 8'h00};

   typedef struct packed {
      logic [15:0] event_serial;
      logic [31:0] timestamp;
      logic [15:0] status_word;
      logic [7:0]  st_vout;
      logic [7:0]  st_iout;
      logic [7:0]  st_input;
      logic [7:0]  st_temp;
      logic [7:0]  st_cml;
      logic [7:0]  misc_status_byte;
      logic [7:0]  vendor_status_byte;
      logic [15:0] vin_val;
      logic [15:0] vout_val;
      logic [15:0] iout_val;
      logic [15:0] temp_val;
   } pmbev_rec_t;
endpackage : pmbev_pkg

//--- design/pmbev_core.sv
// Command interpreter: event block readout, parameter stores, on/off control.
// Assumes an AXI4-Lite master on aclk and a recorder that writes event slots.
module pmbev_core #(
   parameter logic [6:0] DEV_ADDR = 7'h20
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 ev_wr,
   input  wire logic [5:0]           ev_slot,
   input  wire pmbev_pkg::pmbev_rec_t ev_rec,
   input  wire logic [15:0]          vin_meas,
   input  wire logic                 primary_onoff_input,
   input  wire logic                 aux_ctrl_i,
   output logic                      aux_ctrl_o,
   output logic                      aux_ctrl_oe_n,
   output logic                      aux_pullup_en,
   output logic                      out_enable,
   output logic [15:0]               vout_setpoint,
   output logic [15:0]               vout_trim
);
   import pmbev_pkg::*;

   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction : crc8

   typedef enum logic {ST_LOAD, ST_RUN} pmbev_init_t;

   pmbev_init_t    init_r;
   pmbev_cfg_t     cfg_r, user_r;
   pmbev_rec_t     mem [EVT_SLOTS];
   logic [EVT_SLOTS-1:0] full_r;
   logic [EVT_BITS-1:0]  rec_r;
   logic [7:0]     idx_r, crc_r;
   logic [4:0]     pos_r;
   logic [9:0]     prep_r;
   logic           aw_r, w_r, bvalid_r, rvalid_r, berr_r, rerr_r;
   logic [7:0]     awaddr_r, araddr_r;
   logic [31:0]    wdata_r, rdata_r;
   logic [1:0]     pri_s, aux_s;
   logic           uv_ok_r, out_r;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data latch independently.
   wire do_wr    = aw_r && w_r && !bvalid_r;
   wire ready    = (init_r == ST_RUN);
   wire wr_cmd   = do_wr && ready && (awaddr_r == REG_CMD);
   wire [7:0]  cmd_code = wdata_r[7:0];
   wire [15:0] cmd_val  = wdata_r[23:8];
   wire wr_ok    = ready && (awaddr_r == REG_CMD);
   assign s_axi_awready = !aw_r && !bvalid_r;
   assign s_axi_wready  = !w_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = berr_r ? 2'h2 : 2'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_r <= 1'b0; w_r <= 1'b0; bvalid_r <= 1'b0; berr_r <= 1'b0;
         awaddr_r <= 8'h00; wdata_r <= 32'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_r <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_r <= 1'b0; w_r <= 1'b0; bvalid_r <= 1'b1;
            berr_r <= !wr_ok; // Commands before load are refused.
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Working values, user store and initialization.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         init_r <= ST_LOAD;
         cfg_r  <= FACTORY_CFG; // Secondary pin disabled, floating.
         user_r <= FACTORY_CFG;
      end else begin
         case (init_r)
            ST_LOAD: begin
               cfg_r  <= user_r;
               init_r <= ST_RUN;
            end
            ST_RUN: begin
               if (wr_cmd) begin
                  case (cmd_code)
                     CMD_RESTORE_ALL: cfg_r <= FACTORY_CFG;
                     CMD_STORE_USER:  user_r <= cfg_r;
                     CMD_VOUT_SET:    cfg_r.vout_set  <= cmd_val;
                     CMD_VOUT_TRIM:   cfg_r.vout_trim <= cmd_val;
                     CMD_VIN_ON:      cfg_r.vin_on    <= cmd_val;
                     CMD_VIN_OFF:     cfg_r.vin_off   <= cmd_val;
                     CMD_ON_OFF_CFG: cfg_r.onoff_cfg <= cmd_val[7:0];
                     CMD_AUX_SETUP:   cfg_r.aux_setup <= cmd_val[7:0];
                     default: ;
                  endcase
               end
            end
            default: init_r <= ST_LOAD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event slots and block readout. Reading while preparing is undefined.
   wire idx_cmd   = wr_cmd && (cmd_code == CMD_EVENT_INDEX);
   wire rd_cmd    = wr_cmd && (cmd_code == CMD_READ_EVENT);
   wire idx_ok    = (cmd_val[7:0] <= IDX_LAST);
   wire [5:0] sel = idx_r[5:0];
   wire [7:0] seed = crc8(crc8(crc8(8'h00, {DEV_ADDR, 1'b0}),
                                CMD_READ_EVENT), {DEV_ADDR, 1'b1});
   wire [7:0] pay_byte = rec_r[EVT_BITS-1 -: 8];
   wire [7:0] ev_byte  = (pos_r == 5'd0) ? BLOCK_COUNT :
                         (pos_r <= 5'(EVT_BYTES)) ? pay_byte :
                         (pos_r == 5'(EVT_BYTES + 1)) ? crc_r : EMPTY_BYTE;
   wire rd_ev     = s_axi_arvalid && s_axi_arready && ready &&
                    (s_axi_araddr == REG_EVDATA);

   always_ff @(posedge aclk) begin
      if (ev_wr) begin
         mem[ev_slot] <= ev_rec;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_r <= '0; idx_r <= 8'h00; prep_r <= '0;
         rec_r <= '1; pos_r <= 5'(EVT_BYTES + 2); crc_r <= 8'h00;
      end else begin
         if (ev_wr) begin
            full_r[ev_slot] <= 1'b1;
         end
         if (idx_cmd && idx_ok) begin
            idx_r  <= cmd_val[7:0];
            prep_r <= 10'(EVT_PREP_CYC);
         end else if (prep_r != '0) begin
            prep_r <= prep_r - 10'd1;
         end
         if (prep_r == 10'd1) begin
            // Empty slot reads all ones.
            rec_r <= full_r[sel] ? EVT_BITS'(mem[sel]) : '1;
         end
         if (rd_cmd) begin
            pos_r <= 5'd0;
            crc_r <= seed;
         end else if (rd_ev) begin
            if (pos_r <= 5'(EVT_BYTES)) begin
               crc_r <= crc8(crc_r, ev_byte);
               pos_r <= pos_r + 5'd1;
            end else if (pos_r == 5'(EVT_BYTES + 1)) begin
               pos_r <= pos_r + 5'd1;
            end
            if (pos_r != 5'd0 && pos_r <= 5'(EVT_BYTES)) begin
               rec_r <= {rec_r[EVT_BITS-9:0], EMPTY_BYTE};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // On/off control with input-voltage hysteresis.
   wire aux_en   = cfg_r.aux_setup[AUX_ENABLE_BIT];
   wire sec_pos  = cfg_r.onoff_cfg[ONOFF_SEC_POS_BIT];
   wire pri_on   = !pri_s[1];
   wire sec_on   = !aux_en || (aux_s[1] == sec_pos);
   assign aux_ctrl_o    = 1'b0;
   assign aux_ctrl_oe_n = 1'b1;  // The device never drives this pin.
   assign aux_pullup_en = aux_en && cfg_r.aux_setup[AUX_PULLUP_BIT];
   assign out_enable    = out_r;
   assign vout_setpoint = cfg_r.vout_set;
   assign vout_trim     = cfg_r.vout_trim;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pri_s <= 2'b11; aux_s <= 2'b00; uv_ok_r <= 1'b0; out_r <= 1'b0;
      end else begin
         pri_s <= {pri_s[0], primary_onoff_input};
         aux_s <= {aux_s[0], aux_ctrl_i};
         if (vin_meas >= cfg_r.vin_on) begin
            uv_ok_r <= 1'b1;
         end else if (vin_meas < cfg_r.vin_off) begin
            uv_ok_r <= 1'b0;
         end
         out_r <= ready && uv_ok_r && pri_on && sec_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path; reading the event register pops one byte.
   wire [31:0] status_w = {27'h0, |prep_r, pri_on, uv_ok_r, out_r, ready};
   wire [31:0] cfg_w    = {16'h0000, cfg_r.aux_setup, cfg_r.onoff_cfg};
   wire rd_hit = (s_axi_araddr == REG_EVDATA) || (s_axi_araddr == REG_STATUS)
              || (s_axi_araddr == REG_CFG) || (s_axi_araddr == REG_VOUT)
              || (s_axi_araddr == REG_VIN);
   wire [31:0] rd_mux =
      (s_axi_araddr == REG_EVDATA) ? {24'h0, ev_byte} :
      (s_axi_araddr == REG_STATUS) ? status_w :
      (s_axi_araddr == REG_CFG)    ? cfg_w :
      (s_axi_araddr == REG_VOUT)   ? {cfg_r.vout_trim, cfg_r.vout_set} :
      (s_axi_araddr == REG_VIN)    ? {cfg_r.vin_off, cfg_r.vin_on} : 32'h0;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rerr_r ? 2'h2 : 2'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0; rerr_r <= 1'b0; rdata_r <= 32'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rerr_r   <= !rd_hit;
         rdata_r  <= rd_hit ? rd_mux : 32'h0;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_read_start;
      rd_cmd;
   endsequence
   a_block_count: assert property (@(posedge aclk)
      disable iff (!aresetn) s_read_start |=> (ev_byte == BLOCK_COUNT))
      else $error("block count not 23 after read command");
   a_pec_seed: assert property (@(posedge aclk)
      disable iff (!aresetn) s_read_start |=> (crc_r == $past(seed)))
      else $error("PEC not seeded with header bytes");
   a_empty_ff: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (prep_r == 10'd1 && !full_r[sel]) |=> (rec_r == '1))
      else $error("empty slot not all 0xFF");
   a_byte_shift: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (rd_ev && pos_r != 5'd0 && pos_r <= 5'(EVT_BYTES) && !rd_cmd &&
       prep_r != 10'd1) |=> (pay_byte == $past(rec_r[EVT_BITS-9 -: 8])))
      else $error("payload byte order broken");
   a_restore_dflt: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (wr_cmd && cmd_code == CMD_RESTORE_ALL) |=> (cfg_r == FACTORY_CFG))
      else $error("restore did not load factory values");
   a_store_user: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (wr_cmd && cmd_code == CMD_STORE_USER) |=> (user_r == $past(cfg_r)))
      else $error("store did not copy working values");
   a_init_gate: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (init_r == ST_LOAD) |-> !wr_cmd ##1 (cfg_r == $past(user_r)))
      else $error("command accepted before load");
   a_uv_hyst: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (uv_ok_r && vin_meas >= cfg_r.vin_off) |=> uv_ok_r)
      else $error("turn-off above threshold");
   a_pri_neg: assert property (@(posedge aclk)
      disable iff (!aresetn) pri_s[1] |=> !out_r)
      else $error("output on with primary input high");
   a_aux_float: assert property (@(posedge aclk)
      disable iff (!aresetn) !aux_en |-> (aux_ctrl_oe_n && !aux_pullup_en))
      else $error("disabled secondary pin not floating");
   a_vout_update: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (wr_cmd && cmd_code == CMD_VOUT_SET) |=>
      (vout_setpoint == $past(cmd_val)))
      else $error("setpoint not updated");
endmodule : pmbev_core

//--- dv/pmbev_host.sv
// AXI4-Lite master model standing in for the host software.
// Assumes a slave on aclk; a handshake that never completes raises hang.
module pmbev_host (
   input  wire logic        aclk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready,
   output logic             hang
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, hang} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, s_axi_wstrb} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Address and data go out together; each is dropped once it is taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 1000);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 1000) hang <= 1'b1;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 1000);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 1000) hang <= 1'b1;
   endtask : rd
endmodule : pmbev_host

//--- dv/pmbus_event_readout_nvm_onoff_tb.sv
// Self-checking bench for the power-module command interpreter.
// Assumes pmbev_pkg, pmbev_core and pmbev_host are compiled before it.
module pmbus_event_readout_nvm_onoff_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pmbev_pkg::*;
   localparam logic [6:0]  ADDR7    = 7'h20;
   localparam logic [31:0] VOUT_FAC = {FACTORY_CFG.vout_trim,
                                       FACTORY_CFG.vout_set};
   logic        aclk, aresetn, ev_wr, primary_onoff_input, aux_ctrl_i, hang;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, aux_ctrl_o, aux_ctrl_oe_n;
   logic        aux_pullup_en, out_enable;
   logic [15:0] vin_meas, vout_setpoint, vout_trim;
   logic [5:0]  ev_slot;
   pmbev_rec_t  ev_rec;
   int          n_errors = 0, n_compared = 0, seed = 21;

   pmbev_core #(.DEV_ADDR(ADDR7)) DUT (.*);
   pmbev_host host (.*);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cmd(input logic [7:0] code, input logic [15:0] val);
      logic [1:0] r;
      host.wr(REG_CMD, {8'h00, val, code}, r);
      check("cmd resp", 32'(r), 32'h0);
   endtask : cmd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      host.rd(a, d, r);
      check("read data", d, exp);
      check("read resp", 32'(r), 32'(er));
   endtask : rd_chk

   // Eight cycles cover the pin synchronisers and the enable register.
   task automatic settle(input logic exp);
      repeat (8) @(posedge aclk);
      check("out_enable", 32'(out_enable), 32'(exp));
   endtask : settle

   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++) begin
         x = {x[6:0], 1'b0} ^ (x[7] ? CRC_POLY : 8'h00);
      end
      return x;
   endfunction : crc8

   task automatic ev_read(input int s, input pmbev_rec_t rec, input bit full);
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  pec, e;
      int          n;
      cmd(CMD_EVENT_INDEX, 16'(s));
      n = 0;
      do begin
         host.rd(REG_STATUS, d, r);
         n++;
      end while (d[4] !== 1'b0 && n < 1000);
      check("prep done", 32'(d[4]), 32'h0);
      // A record that never gets ready has already counted as a mismatch.
      if (n >= 1000) summarize();
      cmd(CMD_READ_EVENT, 16'h0000);
      pec = crc8(crc8(8'h00, {ADDR7, 1'b0}), CMD_READ_EVENT);
      pec = crc8(pec, {ADDR7, 1'b1});
      for (int i = 0; i < 25; i++) begin
         if (i == 0) e = BLOCK_COUNT;
         else if (i == 24) e = pec;
         else e = full ? 8'(rec >> (8 * (23 - i))) : EMPTY_BYTE;
         host.rd(REG_EVDATA, d, r);
         check("ev byte", 32'(d[7:0]), 32'(e));
         pec = crc8(pec, e);
      end
   endtask : ev_read
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge hang) begin
      n_errors++;
      summarize();
   end

   initial begin
      repeat (90000) @(posedge aclk);
      n_errors++;
      summarize();
   end

   initial begin
      logic [191:0] w;
      logic [15:0]  v, t;
      logic [15:0]  vt [4];
      logic [1:0]   r;
      pmbev_rec_t   rec [3];
      int           sl [3];
      {aresetn, ev_wr, ev_slot, ev_rec, aux_ctrl_i} = '0;
      vin_meas = 16'h0050;
      primary_onoff_input = 1'b1;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      check("oe_n", 32'(aux_ctrl_oe_n), 32'h1);
      check("aux drive", 32'(aux_ctrl_o), 32'h0);
      check("pullup", 32'(aux_pullup_en), 32'h0);
      rd_chk(REG_CFG, 32'h0, 2'b00);
      rd_chk(REG_VOUT, VOUT_FAC, 2'b00);
      rd_chk(8'h18, 32'h0, 2'b10);
      host.wr(REG_VOUT, 32'h1, r);
      check("ro write", 32'(r), 32'h2);
      // Setpoints stay below the factory value so no over-voltage trips.
      repeat (4) begin
         v = 16'($unsigned($random(seed)) % FACTORY_CFG.vout_set);
         t = 16'($random(seed));
         cmd(CMD_VOUT_SET, v);
         cmd(CMD_VOUT_TRIM, t);
         rd_chk(REG_VOUT, {t, v}, 2'b00);
         check("setpoint", {vout_trim, vout_setpoint}, {t, v});
      end
      cmd(CMD_VIN_ON, v);
      cmd(CMD_VIN_OFF, t);
      rd_chk(REG_VIN, {t, v}, 2'b00);
      cmd(CMD_STORE_USER, 16'h0000);
      // The user store has no bus readback, so it is looked at directly.
      w[31:0] = {DUT.user_r.vout_trim, DUT.user_r.vout_set};
      check("user vout", w[31:0], {t, v});
      cmd(CMD_RESTORE_ALL, 16'h0000);
      rd_chk(REG_VOUT, VOUT_FAC, 2'b00);
      primary_onoff_input <= 1'b0;
      vt = '{FACTORY_CFG.vin_on - 16'h1, FACTORY_CFG.vin_on,
             FACTORY_CFG.vin_off, FACTORY_CFG.vin_off - 16'h1};
      for (int k = 0; k < 4; k++) begin
         vin_meas <= vt[k];
         settle(k == 1 || k == 2);
      end
      vin_meas <= FACTORY_CFG.vin_on;
      primary_onoff_input <= 1'b1;
      settle(1'b0);
      primary_onoff_input <= 1'b0;
      settle(1'b1);
      cmd(CMD_AUX_SETUP, 16'h0003);
      check("pullup", 32'(aux_pullup_en), 32'h1);
      check("oe_n", 32'(aux_ctrl_oe_n), 32'h1);
      for (int p = 0; p < 2; p++) begin
         cmd(CMD_ON_OFF_CFG, 16'(p));
         for (int l = 0; l < 2; l++) begin
            aux_ctrl_i <= l[0];
            settle(l == p);
         end
      end
      sl = '{0, 47, 24 + ($unsigned($random(seed)) % 22)};
      for (int k = 0; k < 3; k++) begin
         w = {$random(seed), $random(seed), $random(seed),
              $random(seed), $random(seed), $random(seed)};
         rec[k] = w[183:0];
         @(posedge aclk);
         ev_wr   <= 1'b1;
         ev_slot <= 6'(sl[k]);
         ev_rec  <= rec[k];
         @(posedge aclk);
         ev_wr   <= 1'b0;
      end
      for (int k = 0; k < 3; k++) ev_read(sl[k], rec[k], 1'b1);
      ev_read(sl[1], rec[1], 1'b1);
      ev_read(23, rec[0], 1'b0);
      cmd(CMD_EVENT_INDEX, 16'(EVT_SLOTS));
      host.rd(REG_STATUS, w[31:0], r);
      check("bad index", 32'(w[4]), 32'h0);
      summarize();
   end
endmodule : pmbus_event_readout_nvm_onoff_tb
